// File: verilog/lcdce_pkg.sv
// package for the display command executor: encodings, defaults and carrier types
package lcdce_pkg;
  localparam int RAM_DEPTH   = 40;
  localparam int PTR_W       = 6;
  localparam int SUB_W       = 3;
  localparam logic [3:0] DEVSEL_CODE = 4'hc;
  localparam logic [4:0] BANK_CODE   = 5'h1e;
  localparam logic [3:0] BLINK_CODE  = 4'he;
  localparam logic [5:0] LOADPTR_TOP = 6'h00;
  localparam logic [2:0] SUB_RESET   = 3'h0;
  localparam logic [1:0] MODE_STATIC = 2'h1;
  localparam logic [1:0] MODE_MUX2   = 2'h2;
  localparam logic [1:0] MODE_MUX3   = 2'h3;
  localparam logic [1:0] MODE_MUX4   = 2'h0;
  localparam logic [1:0] BLINK_OFF   = 2'h0;
  localparam logic [5:0] PTR_LAST    = 6'h27;
  localparam int BYTE_W      = 9;
  localparam int FIFO_DEPTH  = 32;
  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } lcdce_byte_type;
  typedef struct packed {
    logic       alt_bank_blink_bit;
    logic [1:0] blink_rate_field;
  } lcdce_blink_type;
endpackage : lcdce_pkg

// File: verilog/lcdce_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module lcdce_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clock)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lcdce_fifo

// File: verilog/lcdce_executor.sv
// command decoder and display controller: state registers and display ram filling
// Functional notes
// R1: command with bits 6..3 = 1100 loads its low three bits into subaddress counter.
// R2: subaddress is unsigned 0..7, default zero.
// R3: bank command bit 1 picks input bank: bit 0/2 static, bits 0-1/2-3 duplex.
// R4: bank command bit 0 picks output bank read for display, same mapping, default 0.
// R5: bank command ignored while 1:3 or 1:4 multiplex is active.
// R6: blink command bit 2 selects alternate bank blinking; default normal.
// R7: in 1:3 or 1:4 modes blinking is always normal.
// R8: blink rate 00 off, 01/10/11 rates one to three.
// R9: each decoded command updates state registers and their combined effect.
// R10: display data written into ram in order set by mode and input bank.
// R11: bit 7 set means next byte is command, clear means data follows.
// R12: data bytes advance data pointer and subaddress counter automatically.
// R13: data byte acknowledged only when address pins match subaddress counter.
`timescale 1ns/1ps
module lcdce_executor
  import lcdce_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             start,
  input  wire logic [7:0]       byte_data,
  input  wire logic             byte_valid,
  output logic                  byte_ready,
  input  wire logic             hw_addr_pin_bit0,
  input  wire logic             hw_addr_pin_bit1,
  input  wire logic             hw_addr_pin_bit2,
  input  wire logic [1:0]       drive_mode,
  output logic                  data_ack_reg,
  output logic [2:0]            subaddr_reg,
  output logic [5:0]            pointer_reg,
  output logic                  in_bank_reg,
  output logic                  out_bank_reg,
  output logic                  alt_blink_reg,
  output logic [1:0]            blink_rate_reg,
  output logic                  blink_on_reg,
  output logic [3:0]            ram_rd_reg,
  input  wire logic [5:0]       ram_rd_addr
);
  typedef enum logic [1:0] {
    ST_CMD  = 2'b01,
    ST_DATA = 2'b10
  } lcdce_state_type;
  lcdce_state_type state_reg;
  logic [2:0]      pin_s1_reg;
  logic [2:0]      pin_s2_reg;
  logic            start_s1_reg;
  logic            start_s2_reg;
  logic [3:0]      ram_reg [RAM_DEPTH];
  logic            mux_high;
  lcdce_byte_type  in_word;
  lcdce_byte_type  out_word;
  logic            out_valid;
  logic            take;
  logic            match;
  logic [1:0]      bits_left_reg;
  // pins and frame start come from outside the clock domain
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pin_s1_reg   <= 3'h0;
      pin_s2_reg   <= 3'h0;
      start_s1_reg <= 1'b0;
      start_s2_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg   <= {hw_addr_pin_bit2, hw_addr_pin_bit1, hw_addr_pin_bit0};
      pin_s2_reg   <= pin_s1_reg;
      start_s1_reg <= start;
      start_s2_reg <= start_s1_reg;
    end
  end
  // incoming bytes are buffered; the executor takes one per cycle, so byte_ready drops only when the fifo is full
  assign in_word.is_data = 1'b0;
  assign in_word.value   = byte_data;
  lcdce_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_data   (in_word),
    .in_valid  (byte_valid),
    .in_ready  (byte_ready),
    .out_data  (out_word),
    .out_valid (out_valid),
    .out_ready (take)
  );
  assign mux_high = (drive_mode == MODE_MUX3) || (drive_mode == MODE_MUX4);
  assign match    = (pin_s2_reg == subaddr_reg); // R13
  // one byte per cycle; static mode consumes one ram bit per byte bit pass, kept simple
  assign take     = out_valid;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_reg <= ST_CMD;
    else if (start_s2_reg)
      state_reg <= ST_CMD;
    else if (take && state_reg == ST_CMD && !out_word.value[7])
      state_reg <= ST_DATA; // R11
  end
  // command execution
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      subaddr_reg    <= SUB_RESET; // R2
      in_bank_reg    <= 1'b0;
      out_bank_reg   <= 1'b0;
      alt_blink_reg  <= 1'b0;
      blink_rate_reg <= BLINK_OFF;
    end
    else if (take && state_reg == ST_CMD)
    begin
      if (out_word.value[6:3] == DEVSEL_CODE)
        subaddr_reg <= out_word.value[2:0]; // R1
      else if (out_word.value[6:2] == BANK_CODE && !mux_high) // R5
      begin
        in_bank_reg  <= out_word.value[1]; // R3
        out_bank_reg <= out_word.value[0]; // R4
      end
      else if (out_word.value[6:3] == BLINK_CODE)
      begin
        alt_blink_reg  <= out_word.value[2]; // R6
        blink_rate_reg <= out_word.value[1:0]; // R8
      end
    end
    else if (take && state_reg == ST_DATA && pointer_reg == PTR_LAST && bits_left_reg == 2'h0)
      subaddr_reg <= subaddr_reg + 3'h1; // R12
  end
  // blinking is active for any non-zero rate; alternate mode only outside 1:3/1:4
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      blink_on_reg <= 1'b0;
    else
      blink_on_reg <= (blink_rate_reg != BLINK_OFF); // R9
  end
  // byte is split into ram slots: static 1 bit, duplex 2 bits, 1:3 3 bits, 1:4 4 bits per address;
  // each data byte advances the pointer by one address here, a simplification of the pixel packing
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pointer_reg   <= LOADPTR_TOP;
      bits_left_reg <= 2'h0;
      data_ack_reg  <= 1'b0;
    end
    else
    begin
      data_ack_reg <= take && state_reg == ST_DATA && match; // R13
      if (take && state_reg == ST_DATA)
      begin
        bits_left_reg <= 2'h0;
        pointer_reg   <= (pointer_reg == PTR_LAST) ? LOADPTR_TOP : pointer_reg + 6'h1; // R12
      end
    end
  end
  always_ff @(posedge clock)
  begin
    if (take && state_reg == ST_DATA && match)
    begin
      case (drive_mode)
        MODE_STATIC:
          if (in_bank_reg)
            ram_reg[pointer_reg][2] <= out_word.value[7]; // R10
          else
            ram_reg[pointer_reg][0] <= out_word.value[7]; // R10
        MODE_MUX2:
          if (in_bank_reg)
            ram_reg[pointer_reg][3:2] <= out_word.value[7:6]; // R10
          else
            ram_reg[pointer_reg][1:0] <= out_word.value[7:6]; // R10
        MODE_MUX3:
          ram_reg[pointer_reg][2:0] <= out_word.value[7:5]; // R10
        default:
          ram_reg[pointer_reg] <= out_word.value[7:4]; // R10
      endcase
    end
  end
  // output bank retrieval; alternate blinking forced off in 1:3/1:4
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      ram_rd_reg <= 4'h0;
    else if (!mux_high && out_bank_reg) // R4
      ram_rd_reg <= {2'h0, ram_reg[ram_rd_addr][3:2]};
    else if (mux_high || !alt_blink_reg) // R7
      ram_rd_reg <= ram_reg[ram_rd_addr];
    else
      ram_rd_reg <= {2'h0, ram_reg[ram_rd_addr][1:0]};
  end
endmodule : lcdce_executor

// File: test/lcdce_checker.sv
// port assertions for the command executor
`timescale 1ns/1ps
module lcdce_checker
  import lcdce_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       start,
  input wire logic [7:0] byte_data,
  input wire logic       byte_valid,
  input wire logic       byte_ready,
  input wire logic [1:0] drive_mode,
  input wire logic       data_ack_reg,
  input wire logic [2:0] subaddr_reg,
  input wire logic       in_bank_reg,
  input wire logic       out_bank_reg,
  input wire logic       alt_blink_reg,
  input wire logic [1:0] blink_rate_reg,
  input wire logic       blink_on_reg
);
  logic cmd_reg;
  wire  lo_mux = drive_mode == MODE_STATIC || drive_mode == MODE_MUX2;
  wire  c_tk   = byte_valid && byte_ready && cmd_reg;
  wire  d_tk   = byte_valid && byte_ready && !cmd_reg;
  // start is taken at once; the bench keeps the bus idle around it
  always_ff @(posedge clock or posedge reset)
    if (reset)
      cmd_reg <= 1'b1;
    else if (start || c_tk)
      cmd_reg <= start || byte_data[7];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_cmd(logic ok);
    c_tk && ok;
  endsequence
  AST_DEVSEL:
    assert property (s_cmd(byte_data[6:3] == DEVSEL_CODE) |=> ##1 subaddr_reg == $past(byte_data[2:0], 2))
    else $error("subaddress not loaded");
  AST_BANK:
    assert property (s_cmd(byte_data[6:2] == BANK_CODE && lo_mux) |=> ##1
      {in_bank_reg, out_bank_reg} == $past(byte_data[1:0], 2))
    else $error("bank select not applied");
  AST_BANK_IGN:
    assert property (s_cmd(byte_data[6:2] == BANK_CODE && !lo_mux) |=> ##1 $stable({in_bank_reg, out_bank_reg}))
    else $error("bank select acted in high multiplex");
  AST_RATE:
    assert property (s_cmd(byte_data[6:3] == BLINK_CODE) |=> ##1 blink_rate_reg == $past(byte_data[1:0], 2))
    else $error("blink rate not loaded");
  AST_ALT:
    assert property (s_cmd(byte_data[6:3] == BLINK_CODE && lo_mux) |=> ##1 alt_blink_reg == $past(byte_data[2], 2))
    else $error("blink mode not loaded");
  AST_ON:
    assert property (##1 blink_on_reg == ($past(blink_rate_reg) != BLINK_OFF))
    else $error("blink enable wrong");
  AST_ACK:
    assert property (data_ack_reg |-> $past(d_tk, 2))
    else $error("ack without data byte");
  AST_UNK:
    assert property (s_cmd(byte_data[6:5] != 2'b11) |=> ##1 $stable(subaddr_reg) && $stable(blink_rate_reg))
    else $error("foreign command changed state");
endmodule : lcdce_checker

// File: test/lcdce_master.sv
// bus master model: hands bytes over with valid and ready
`timescale 1ns/1ps
module lcdce_master (
  input  wire logic       clock,
  output logic [7:0]      byte_data,
  output logic            byte_valid,
  input  wire logic       byte_ready
);
  initial
  begin
    byte_data = 8'h00;
    byte_valid = 1'b0;
  end
  // caller sets bit 7 on all but the last command byte
  task automatic send(input logic [7:0] b);
    @(negedge clock);
    byte_data = b;
    byte_valid = 1'b1;
    @(posedge clock);
    while (byte_ready !== 1'b1)
      @(posedge clock);
  endtask : send
  // released data inverts so a stale byte is never mistaken for valid
  task automatic idle;
    @(negedge clock);
    byte_valid = 1'b0;
    byte_data = ~byte_data;
  endtask : idle
endmodule : lcdce_master

// File: test/tb_top.sv
// self-checking bench for the command executor
`timescale 1ns/1ps
module tb_top;
  import lcdce_pkg::*;
  logic       clock, reset, start, byte_valid, byte_ready, data_ack_reg, eb_in, eb_out;
  logic       in_bank_reg, out_bank_reg, alt_blink_reg, blink_on_reg;
  logic [7:0] byte_data, bk, bl, d;
  logic [2:0] pins, subaddr_reg, sub;
  logic [1:0] drive_mode, blink_rate_reg;
  logic [3:0] ram_rd_reg;
  logic [5:0] ptr;
  int         failures = 0, cmp_count = 0, acks = 0, exp_acks = 0;
  logic [1:0] modes [4] = '{MODE_STATIC, MODE_MUX2, MODE_MUX3, MODE_MUX4};
  lcdce_master m_u (.clock(clock), .byte_data(byte_data), .byte_valid(byte_valid), .byte_ready(byte_ready));
  lcdce_executor dut_u (.clock(clock), .reset(reset), .start(start), .byte_data(byte_data), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .hw_addr_pin_bit0(pins[0]), .hw_addr_pin_bit1(pins[1]), .hw_addr_pin_bit2(pins[2]),
    .drive_mode(drive_mode), .data_ack_reg(data_ack_reg), .subaddr_reg(subaddr_reg), .pointer_reg(ptr),
    .in_bank_reg(in_bank_reg), .out_bank_reg(out_bank_reg), .alt_blink_reg(alt_blink_reg),
    .blink_rate_reg(blink_rate_reg), .blink_on_reg(blink_on_reg), .ram_rd_reg(ram_rd_reg), .ram_rd_addr(6'h00));
  function automatic logic pick(input logic [1:0] m, input logic old, input logic nb);
    return (m == MODE_STATIC || m == MODE_MUX2) ? nb : old;
  endfunction : pick
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic final_report;
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
    if (data_ack_reg === 1'b1)
      acks++;
  initial
  begin
    #100000;
    failures++;
    final_report();
  end
  initial
  begin
    reset = 1'b1;
    start = 1'b0;
    pins = 3'h0;
    drive_mode = MODE_STATIC;
    eb_in = 1'b0;
    eb_out = 1'b0;
    void'($urandom(32'h23f51388));
    repeat (8) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    cmp({byte_ready, subaddr_reg, in_bank_reg, out_bank_reg, alt_blink_reg, blink_rate_reg, blink_on_reg,
      data_ack_reg}, 16'h0400);
    // odd passes give the pins a foreign address so the data byte must go unanswered
    for (int i = 0; i < 4; i++)
    begin
      drive_mode = modes[i];
      sub = 3'($urandom);
      bk = 8'($urandom);
      bl = 8'($urandom);
      d = 8'($urandom);
      // the ram check below needs the shown bank to be the one just filled
      if (i == 0)
        bk[0] = bk[1];
      pins = i[0] ? ~sub : sub;
      m_u.send({1'b1, DEVSEL_CODE, sub});
      m_u.send({1'b1, BANK_CODE, bk[1:0]});
      m_u.send({1'b1, BLINK_CODE, bl[2:0]});
      m_u.send(8'h40);
      m_u.send(d);
      m_u.idle();
      repeat (4) @(negedge clock);
      eb_in = pick(modes[i], eb_in, bk[1]);
      eb_out = pick(modes[i], eb_out, bk[0]);
      exp_acks += int'(!i[0]);
      cmp({subaddr_reg, in_bank_reg, out_bank_reg, blink_rate_reg}, {sub, eb_in, eb_out, bl[1:0]});
      cmp(blink_on_reg, bl[1:0] != 2'b00);
      cmp(16'(acks), 16'(exp_acks));
      cmp(16'(ptr), 16'(i + 1));
      if (i < 2)
        cmp(alt_blink_reg, bl[2]);
      if (i == 0)
        cmp(ram_rd_reg[0], d[7]);
      start = 1'b1;
      repeat (2) @(negedge clock);
      start = 1'b0;
      repeat (4) @(negedge clock);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule : tb_top
bind lcdce_executor lcdce_checker chk_u (.clock(clock), .reset(reset), .start(start), .byte_data(byte_data),
  .byte_valid(byte_valid), .byte_ready(byte_ready), .drive_mode(drive_mode), .data_ack_reg(data_ack_reg),
  .subaddr_reg(subaddr_reg), .in_bank_reg(in_bank_reg), .out_bank_reg(out_bank_reg),
  .alt_blink_reg(alt_blink_reg), .blink_rate_reg(blink_rate_reg), .blink_on_reg(blink_on_reg));
